// file: dv/spl_host_model.sv
// Purpose: serial host that frames read-back accesses to the protection logic
// Assumes: mode 0 or mode 3 idle level, one ref clock per serial level, two for sck high on a read bit
// Notes:   lines change 1 ns after a ref edge; si is inverted once released
`timescale 1ns/10ps
module spl_host_model (
    input wire logic clk_i,
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    // idle: deselected, clock still
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    // advance to just after the next rising edge
    task automatic step();
        @(posedge clk_i);
        #1;
    endtask

    // opcode, 24 address bits, then nrd output bits (first bit lands in rd[nrd-1])
    task automatic access(input logic [7:0] opc, input logic [23:0] addr, input logic mode3, input int nrd,
                          output logic [15:0] rd, output logic oe_all, output logic oe_end);
        logic [31:0] frame;
        frame = {opc, addr};
        rd = 16'h0000;
        oe_all = 1'b1;
        // idle level settles before select so no false edge is seen
        step();
        sck_o = mode3;
        step();
        cs_n_o = 1'b0;
        // msb first, data valid while the clock is high
        for (int i = 31; i >= 0; i--) begin
            step();
            sck_o = 1'b0;
            step();
            sck_o = 1'b1;
            si_o = frame[i];
        end
        // clock out nrd bits; each is sampled one ref clock after sck goes high
        for (int k = 0; k < nrd; k++) begin
            step();
            sck_o = 1'b0;
            si_o = ~si_o;
            step();
            sck_o = 1'b1;
            step();
            // a released line reads back as the inverse of its last level
            rd = {rd[14:0], so_oe_i ? so_i : ~so_i};
            oe_all = oe_all & so_oe_i;
        end
        // deselect first, then park the clock at its idle level
        step();
        cs_n_o = 1'b1;
        si_o = ~si_o;
        step();
        sck_o = mode3;
        step();
        oe_end = so_oe_i;
    endtask
endmodule

// file: dv/spl_sector_protect_lock_test.sv
// Purpose: self-checking bench for the sector protection and lock logic
// Assumes: 25 MHz ref clock, strobes one cycle wide, default 64 sectors
// Notes:   expected values follow the locking rules, never the outputs
`timescale 1ns/10ps
module spl_sector_protect_lock_test;
    logic ref_clk, resetn, wp_n, prot_sector, unprot_sector, stat_wr, cs_n, sck, si;
    logic so, so_oe, lock, hw_locked;
    logic [5:0] cmd_sector;
    logic [7:0] stat_data;
    logic [1:0] summary;
    int num_errors = 0;
    int n_checks = 0;
    localparam logic [1:0] ALL = spl_pkg::SWP_ALL;
    localparam logic [1:0] SOME = spl_pkg::SWP_SOME;
    localparam logic [1:0] NONE = spl_pkg::SWP_NONE;

    // ----------------------------------------------------------------
    // clock, dut and host
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    spl_sector_protect_lock #(.SECT_W(6)) u_dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .cs_n_i(cs_n),
        .sck_i(sck), .si_i(si), .wp_n_i(wp_n), .prot_sector_i(prot_sector), .unprot_sector_i(unprot_sector),
        .cmd_sector_i(cmd_sector), .stat_wr_i(stat_wr), .stat_data_i(stat_data), .so_o(so), .so_oe_o(so_oe),
        .protection_regs_lock_bit_o(lock), .hw_locked_o(hw_locked), .software_protect_summary_o(summary));
    spl_host_model u_host (.clk_i(ref_clk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tk();
        @(posedge ref_clk);
        #1;
    endtask
    // reset held six cycles, released just after an edge
    task automatic do_reset();
        resetn = 1'b0;
        repeat (6) tk();
        resetn = 1'b1;
    endtask
    // one-cycle command strobe
    task automatic cmd(input logic p, input logic u, input logic [5:0] sec, input logic w, input logic [7:0] d);
        tk();
        prot_sector = p;
        unprot_sector = u;
        cmd_sector = sec;
        stat_wr = w;
        stat_data = d;
        tk();
        prot_sector = 1'b0;
        unprot_sector = 1'b0;
        stat_wr = 1'b0;
    endtask
    task automatic st(input logic l, input logic h, input logic [1:0] s);
        check({12'h000, lock, hw_locked, summary}, {12'h000, l, h, s});
    endtask
    // two full bytes of read-back, then deselect
    task automatic rd_chk(input logic [23:0] addr, input logic mode3, input logic b);
        logic [15:0] r;
        logic a, e;
        u_host.access(spl_pkg::OPC_RD_PROT, addr, mode3, 16, r, a, e);
        check(r, {16{b}});
        check({14'h0000, a, e}, 16'h0002);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_power_up();
        st(1'b0, 1'b0, ALL);
        rd_chk(24'h00_0000, 1'b0, 1'b1);
        rd_chk(24'hFF_FFFF, 1'b1, 1'b1);
    endtask
    task automatic t_sector();
        cmd(1'b0, 1'b1, 6'h05, 1'b0, 8'h00);
        st(1'b0, 1'b0, SOME);
        rd_chk(24'hC5_1234, 1'b1, 1'b0);
        rd_chk(24'h04_FFFF, 1'b0, 1'b1);
        cmd(1'b1, 1'b1, 6'h05, 1'b0, 8'h00);
        st(1'b0, 1'b0, ALL);
        cmd(1'b0, 1'b1, 6'h02, 1'b1, 8'h04);
        st(1'b0, 1'b0, ALL);
    endtask
    task automatic t_global();
        wp_n = 1'b0;
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h00);
        st(1'b0, 1'b0, NONE);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h78);
        st(1'b0, 1'b0, NONE);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h3C);
        st(1'b0, 1'b0, ALL);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h43);
        cmd(1'b1, 1'b0, 6'h09, 1'b0, 8'h00);
        st(1'b0, 1'b0, SOME);
        wp_n = 1'b1;
    endtask
    task automatic t_soft_lock();
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'hBC);
        st(1'b1, 1'b0, ALL);
        cmd(1'b0, 1'b1, 6'h09, 1'b0, 8'h00);
        st(1'b1, 1'b0, ALL);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h80);
        st(1'b1, 1'b0, ALL);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h00);
        st(1'b0, 1'b0, ALL);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h00);
        st(1'b0, 1'b0, NONE);
    endtask
    task automatic t_hw_lock();
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'hBC);
        wp_n = 1'b0;
        tk();
        st(1'b1, 1'b1, ALL);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h00);
        cmd(1'b0, 1'b1, 6'h03, 1'b0, 8'h00);
        st(1'b1, 1'b1, ALL);
        rd_chk(24'h03_8000, 1'b0, 1'b1);
        do_reset();
        st(1'b0, 1'b0, ALL);
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h80);
        st(1'b1, 1'b1, NONE);
        wp_n = 1'b1;
        tk();
        cmd(1'b0, 1'b0, 6'h00, 1'b1, 8'h3C);
        st(1'b0, 1'b0, NONE);
        cmd(1'b1, 1'b0, 6'h03, 1'b0, 8'h00);
        st(1'b0, 1'b0, SOME);
        rd_chk(24'h03_0000, 1'b1, 1'b1);
    endtask
    task automatic t_abort();
        logic [15:0] r;
        logic a, e;
        u_host.access(spl_pkg::OPC_RD_PROT, 24'h03_0001, 1'b0, 3, r, a, e);
        check({13'h0000, r[2:0]}, 16'h0007);
        check({14'h0000, a, e}, 16'h0002);
        u_host.access(spl_pkg::OPC_RD_PROT ^ 8'h01, 24'h03_0001, 1'b0, 4, r, a, e);
        check({14'h0000, a, e}, 16'h0000);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        {resetn, prot_sector, unprot_sector, stat_wr} = 4'h0;
        wp_n = 1'b1;
        cmd_sector = 6'h00;
        stat_data = 8'h00;
        do_reset();
        t_power_up();
        t_sector();
        t_global();
        t_soft_lock();
        t_hw_lock();
        t_abort();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
endmodule

// file: inc/spl_pkg.sv
// Purpose: shared constants and types for the sector protection and lock logic
// Assumes: 24-bit serial addressing, one protection bit per 64 KB sector
// Notes:   every number used by the design files is named here once
package spl_pkg;

    // ---------------------------------------------------------------
    // serial command framing
    // ---------------------------------------------------------------
    localparam logic [7:0] OPC_RD_PROT = 8'h3C;    // read one sector's protection bit
    localparam logic [4:0] CNT_OPC_LAST = 5'h07;   // last opcode bit index
    localparam logic [4:0] CNT_ADDR_LAST = 5'h17;  // last of 24 address bits
    localparam int ADDR_BITS = 24;                 // address width on the wire
    localparam int SECT_LSB = 16;                  // 64 KB sector granularity
    localparam int SECT_W = 6;                     // 64 sectors

    // ---------------------------------------------------------------
    // first status byte layout
    // ---------------------------------------------------------------
    localparam int STAT_LOCK_POS = 7;              // stored lock bit
    localparam int STAT_GLB_HI = 5;                // global op field, top
    localparam int STAT_GLB_LO = 2;                // global op field, bottom
    localparam logic [3:0] GLB_UNPROT = 4'h0;      // all sectors to 0
    localparam logic [3:0] GLB_PROT = 4'hF;        // all sectors to 1

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic PROT_RST = 1'b1;              // sectors power up protected
    localparam logic LOCK_RST = 1'b0;              // lock bit powers up clear

    // ---------------------------------------------------------------
    // software protection summary codes
    // ---------------------------------------------------------------
    localparam logic [1:0] SWP_NONE = 2'h0;        // no sector protected
    localparam logic [1:0] SWP_SOME = 2'h1;        // some sectors protected
    localparam logic [1:0] SWP_ALL = 2'h3;         // every sector protected

    // ---------------------------------------------------------------
    // serial front-end states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SPL_ST_OPC  = 2'b00,                       // collecting opcode
        SPL_ST_ADDR = 2'b01,                       // collecting address
        SPL_ST_DATA = 2'b10,                       // streaming protection byte
        SPL_ST_SKIP = 2'b11                        // foreign opcode, wait for deselect
    } spl_state_e;

endpackage

// file: rtl/spl_prot_store.sv
// Purpose: sector protection bits, lock bit and locking decisions
// Assumes: command strobes are one-cycle pulses from the command decoder
// Notes:   summary is registered so the top can drive it straight from flops
`timescale 1ns/10ps
module spl_prot_store #(
    parameter int SECT_W = spl_pkg::SECT_W
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic wp_n_i,
    input wire logic prot_sector_i,
    input wire logic unprot_sector_i,
    input wire logic [SECT_W-1:0] cmd_sector_i,
    input wire logic stat_wr_i,
    input wire logic [7:0] stat_data_i,
    input wire logic [SECT_W-1:0] rd_sector_i,
    output logic rd_bit_o,
    output logic lock_o,
    output logic hw_lock_o,
    output logic [1:0] summary_o
);
    localparam int NS = 1 << SECT_W;

    logic [NS-1:0] prot_q, prot_d;   // one protection bit per sector
    logic lock_q, lock_d;            // protection registers lock bit
    logic hw_q, hw_d;                // hardware lock state
    logic [1:0] swp_q, swp_d;        // registered summary
    logic hw_now;                    // hardware lock this cycle
    logic [3:0] glb;                 // decoded global op field

    // ---------------------------------------------------------------
    // next-state of protection and lock
    // ---------------------------------------------------------------
    always_comb begin
        prot_d = prot_q;
        lock_d = lock_q;
        hw_now = !wp_n_i && lock_q;
        glb = stat_data_i[spl_pkg::STAT_GLB_HI:spl_pkg::STAT_GLB_LO];
        if (hw_now) begin
            // everything frozen, all commands ignored
        end else if (stat_wr_i) begin
            lock_d = stat_data_i[spl_pkg::STAT_LOCK_POS];  // only bit 7 stored
            if (!lock_q) begin
                // unlocked: global op allowed, also on 0->1
                if (glb == spl_pkg::GLB_UNPROT) begin
                    prot_d = '0;
                end else if (glb == spl_pkg::GLB_PROT) begin
                    prot_d = '1;
                end
            end
            // soft-locked: clearing lock never does global
        end else if (!lock_q) begin
            // sector commands only while unlocked
            if (prot_sector_i) begin
                prot_d[cmd_sector_i] = 1'b1;
            end else if (unprot_sector_i) begin
                prot_d[cmd_sector_i] = 1'b0;
            end
        end
        hw_d = !wp_n_i && lock_d;
        // summary of all / some / none
        if (&prot_d) begin
            swp_d = spl_pkg::SWP_ALL;
        end else if (|prot_d) begin
            swp_d = spl_pkg::SWP_SOME;
        end else begin
            swp_d = spl_pkg::SWP_NONE;
        end
    end

    // ---------------------------------------------------------------
    // registers; power-up protected and unlocked
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prot_q <= {NS{spl_pkg::PROT_RST}};
            lock_q <= spl_pkg::LOCK_RST;
            hw_q <= 1'b0;
            swp_q <= spl_pkg::SWP_ALL;
        end else begin
            prot_q <= prot_d;
            lock_q <= lock_d;
            hw_q <= hw_d;
            swp_q <= swp_d;
        end
    end

    // stored bit only, wp pin plays no part
    assign rd_bit_o = prot_q[rd_sector_i];
    assign lock_o = lock_q;
    assign hw_lock_o = hw_q;
    assign summary_o = swp_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_HW_FREEZE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!wp_n_i && lock_q) |=> ($stable(prot_q) && lock_q))
        else $error("hardware lock let protection or lock change");
    AST_SOFT_NO_SECT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (lock_q && !stat_wr_i && (prot_sector_i || unprot_sector_i)) |=> $stable(prot_q))
        else $error("sector command accepted while locked");
    AST_UNLOCK_NO_GLOBAL: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (lock_q && stat_wr_i) |=> $stable(prot_q))
        else $error("global op performed while locked");
    AST_GLOBAL_PROT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!lock_q && stat_wr_i && glb == spl_pkg::GLB_PROT)
        |=> (&prot_q && lock_q == $past(stat_data_i[spl_pkg::STAT_LOCK_POS])))
        else $error("global protect not applied");
    AST_SUMMARY: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ##1 (summary_o == ((&prot_q) ? spl_pkg::SWP_ALL : ((|prot_q) ? spl_pkg::SWP_SOME : spl_pkg::SWP_NONE))))
        else $error("protection summary wrong");
    COV_GLOBAL_UNPROT: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !lock_q && stat_wr_i && glb == spl_pkg::GLB_UNPROT ##1 prot_q == '0);
    COV_HW_LOCK: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        hw_q && stat_wr_i);

endmodule

// file: rtl/spl_sector_protect_lock.sv
// Purpose: serial read-back of a sector's protection bit plus lock logic
// Assumes: all inputs synchronous to ref_clk_i; sck_i is sampled, not a clock
// Notes:   protect, unprotect and status write arrive as decoded strobes
//
// Function
// - opcode 3Ch plus three address bytes
// - drive output every clock after address
// - byte all ones or zeros per bit
// - deselect ends read, output released
// - read-back ignores write-protect pin level
// - summary shows all, some, none protected
// - hardware lock needs pin low, lock set
// - hardware lock freezes bits and writes
// - clearing lock performs no global op
// - lock clears by reset or by status write unless hw locked
// - power-up all protected, lock clear
// - lock set ignores sector commands
// - setting lock may do global op
// - lock clear leaves everything modifiable
// - locked states refuse global operations
// - store bit 7, decode bits 5-2
`timescale 1ns/10ps
module spl_sector_protect_lock #(
    parameter int SECT_W = spl_pkg::SECT_W
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic prot_sector_i,
    input wire logic unprot_sector_i,
    input wire logic [SECT_W-1:0] cmd_sector_i,
    input wire logic stat_wr_i,
    input wire logic [7:0] stat_data_i,
    output logic so_o,
    output logic so_oe_o,
    output logic protection_regs_lock_bit_o,
    output logic hw_locked_o,
    output logic [1:0] software_protect_summary_o
);

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    // sector field must fit inside the 24-bit address
    if (SECT_W < 1 || spl_pkg::SECT_LSB + SECT_W > spl_pkg::ADDR_BITS) begin : g_bad_sect
        $error("SECT_W does not fit the serial address");
    end

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    spl_pkg::spl_state_e st_q, st_d;         // serial front-end state
    logic [4:0] cnt_q, cnt_d;                // bit counter within a field
    logic [23:0] sr_q, sr_d;                 // incoming shift register
    logic [SECT_W-1:0] sect_q, sect_d;       // latched sector index
    logic sck_q, sck_d;                      // previous sampled sck
    logic so_q, so_d;                        // serial output data
    logic oe_q, oe_d;                        // serial output enable
    logic sck_rise;                          // sample edge
    logic sck_fall;                          // drive edge
    logic rd_bit;                            // stored bit of latched sector
    logic lock_bit;                          // lock bit from the store
    logic hw_lock;                           // hardware lock from the store
    logic [1:0] software_protect_summary;                         // summary from the store

    // ---------------------------------------------------------------
    // sck edge detection on the reference clock
    // ---------------------------------------------------------------
    // works for both idle levels of sck
    assign sck_rise = sck_i && !sck_q;
    assign sck_fall = !sck_i && sck_q;

    // ---------------------------------------------------------------
    // serial front-end next state
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        sect_d = sect_q;
        so_d = so_q;
        oe_d = oe_q;
        sck_d = sck_i;
        if (cs_n_i) begin
            // deselected: abort any frame, release output
            st_d = spl_pkg::SPL_ST_OPC;
            cnt_d = '0;
            oe_d = 1'b0;
            so_d = 1'b0;
        end else begin
            if (sck_rise) begin
                // sample input on rising edge
                sr_d = {sr_q[22:0], si_i};
                unique case (st_q)
                    spl_pkg::SPL_ST_OPC: begin
                        if (cnt_q == spl_pkg::CNT_OPC_LAST) begin
                            cnt_d = '0;
                            // only the protection read is served here
                            if (sr_d[7:0] == spl_pkg::OPC_RD_PROT) begin
                                st_d = spl_pkg::SPL_ST_ADDR;
                            end else begin
                                st_d = spl_pkg::SPL_ST_SKIP;
                            end
                        end else begin
                            cnt_d = cnt_q + 5'h01;
                        end
                    end
                    spl_pkg::SPL_ST_ADDR: begin
                        if (cnt_q == spl_pkg::CNT_ADDR_LAST) begin
                            cnt_d = '0;
                            st_d = spl_pkg::SPL_ST_DATA;
                            // upper address bits pick the sector
                            sect_d = sr_d[spl_pkg::SECT_LSB +: SECT_W];
                        end else begin
                            cnt_d = cnt_q + 5'h01;
                        end
                    end
                    spl_pkg::SPL_ST_DATA: begin
                        // further input ignored while streaming
                    end
                    spl_pkg::SPL_ST_SKIP: begin
                        // foreign command, wait for deselect
                    end
                endcase
            end
            if (sck_fall && st_q == spl_pkg::SPL_ST_DATA) begin
                // each falling edge drives the next bit: a constant
                // bit repeats as an all-ones or all-zeros byte
                so_d = rd_bit;
                oe_d = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // serial front-end registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= spl_pkg::SPL_ST_OPC;
            cnt_q <= '0;
            sr_q <= '0;
            sect_q <= '0;
            sck_q <= 1'b0;
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            sect_q <= sect_d;
            sck_q <= sck_d;
            so_q <= so_d;
            oe_q <= oe_d;
        end
    end

    // ---------------------------------------------------------------
    // protection bits and locking
    // ---------------------------------------------------------------
    spl_prot_store #(
        .SECT_W(SECT_W)
    ) u_store (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .wp_n_i(wp_n_i),
        .prot_sector_i(prot_sector_i),
        .unprot_sector_i(unprot_sector_i),
        .cmd_sector_i(cmd_sector_i),
        .stat_wr_i(stat_wr_i),
        .stat_data_i(stat_data_i),
        .rd_sector_i(sect_q),
        .rd_bit_o(rd_bit),
        .lock_o(lock_bit),
        .hw_lock_o(hw_lock),
        .summary_o(software_protect_summary)
    );

    // ---------------------------------------------------------------
    // outputs, all from flops
    // ---------------------------------------------------------------
    assign so_o = so_q;
    assign so_oe_o = oe_q;
    assign protection_regs_lock_bit_o = lock_bit;   // lock_q inside the store
    assign hw_locked_o = hw_lock;                   // hw_q inside the store
    assign software_protect_summary_o = software_protect_summary;        // swp_q inside the store

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // deselect releases the output on the next cycle
    AST_SO_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cs_n_i |=> (!so_oe_o && st_q == spl_pkg::SPL_ST_OPC))
        else $error("output still driven after deselect");

    // last address bit moves the front-end to streaming
    AST_ADDR_DONE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!cs_n_i && sck_rise && st_q == spl_pkg::SPL_ST_ADDR && cnt_q == spl_pkg::CNT_ADDR_LAST)
        |=> (st_q == spl_pkg::SPL_ST_DATA && sect_q == $past(sr_q[spl_pkg::SECT_LSB-1 +: SECT_W])))
        else $error("address phase did not end after 24 bits");

    // every falling edge in streaming drives the stored bit
    AST_DRIVE_BIT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!cs_n_i && sck_fall && st_q == spl_pkg::SPL_ST_DATA) |=> (so_oe_o && so_o == $past(rd_bit)))
        else $error("protection bit not driven on falling edge");

    // output only ever enabled while streaming and selected
    AST_OE_ONLY_DATA: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        so_oe_o |-> ($past(st_q) == spl_pkg::SPL_ST_DATA && !$past(cs_n_i))
        && (so_o == u_store.prot_q[sect_q]))
        else $error("output driven outside a protection read");

    COV_READ_STREAM: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        so_oe_o ##1 cs_n_i ##1 !so_oe_o);
    COV_FOREIGN_OPC: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
        st_q == spl_pkg::SPL_ST_SKIP);

endmodule
